// ==== memory_wait_state_handshake.sv ====
// Processor-side memory bus engine with wait-state handshakes
//
// Notes on behaviour
// - Read qualifier selects one or four words
// - Write qualifier marks same 256-word page
// - Mode vector captured from interrupts at release
// - Enable sampled, buffer clocked next half cycle; here the buffer is written one clock later
// - Burst drain word per clock after acknowledge
// - Write ends on acknowledge sampled
// - Strobe drops clock after bus error
// - Bus error exception only on reads
// - All handshake inputs sampled on rising edge
`timescale 1ns/1ps
`default_nettype none
module memory_wait_state_handshake
    import memory_wait_state_pkg::*;
(
    input  wire logic                  clock,
    input  wire logic                  reset,
    // User request side
    input  wire logic                  requestValid,
    input  wire logic                  requestWrite,
    input  wire logic                  requestBurst,
    input  wire logic [ADDR_WIDTH-1:0] requestAddress,
    input  wire logic [DATA_WIDTH-1:0] requestData,
    output logic                       requestReady,
    output logic                       readDataValid,
    output logic [DATA_WIDTH-1:0]      readData,
    output logic                       readDone,
    output logic                       writeDone,
    output logic                       busErrorException,
    // Memory bus side
    output logic                       readStrobe,
    output logic                       writeStrobe,
    output logic                       burst_or_near_write,
    output logic                       data_drive_enable,
    output logic [ADDR_WIDTH-1:0]      busAddress,
    output logic [DATA_WIDTH-1:0]      busWriteData,
    input  wire logic [DATA_WIDTH-1:0] busReadData,
    input  wire logic                  read_buffer_clock_enable,
    input  wire logic                  acknowledge,
    input  wire logic                  bus_fault_input,
    // Reset-time mode vector
    input  wire logic [MODE_WIDTH-1:0] mode_vector_interrupt_inputs,
    output logic                       byte_order_select,
    output logic                       data_refill_block_select
);
    // ==========================================================
    // Declarations
    bus_state_type               state_reg;
    logic                        inReset_reg;
    logic                        burst_reg;
    logic                        enableSeen_reg;
    logic [DATA_WIDTH-1:0]       sampledData_reg;
    logic [WORD_INDEX_WIDTH:0]   filled_reg;
    logic [WORD_INDEX_WIDTH:0]   drained_reg;
    logic                        drainGo_reg;
    logic [ADDR_WIDTH-1:PAGE_LOW_BIT] lastPage_reg;
    logic                        lastPageValid_reg;
    logic [WORD_INDEX_WIDTH:0]   wordsWanted;
    logic                        startRead;
    logic                        startWrite;
    read_buffer_if               bufferPort ();

    function automatic logic samePage(input logic [ADDR_WIDTH-1:0] address,
            input logic [ADDR_WIDTH-1:PAGE_LOW_BIT] page, input logic valid);
        samePage = valid && (address[ADDR_WIDTH-1:PAGE_LOW_BIT] == page);
    endfunction : samePage

    assign startRead  = (state_reg == STATE_IDLE) && requestValid
                        && !requestWrite;
    assign startWrite = (state_reg == STATE_IDLE) && requestValid
                        && requestWrite;
    assign wordsWanted = burst_reg ? (WORD_INDEX_WIDTH + 1)'(BURST_WORDS)
                                   : (WORD_INDEX_WIDTH + 1)'(1);

    // ==========================================================
    // Mode vector capture at reset release
    // Caught in the first cycle after release, never by the reset itself
    always_ff @(posedge clock) begin
        if (reset) begin
            inReset_reg              <= 1'b1;
            byte_order_select        <= BYTE_ORDER_RESET;
            data_refill_block_select <= REFILL_RESET;
        end else if (inReset_reg) begin
            inReset_reg              <= 1'b0;
            byte_order_select        <=
                mode_vector_interrupt_inputs[MODE_BYTE_ORDER_BIT];
            data_refill_block_select <=
                mode_vector_interrupt_inputs[MODE_REFILL_BIT];
        end
    end

    // ==========================================================
    // Cycle state machine
    always_ff @(posedge clock) begin
        if (reset) begin
            state_reg <= STATE_IDLE;
        end else begin
            case (state_reg)
                STATE_IDLE: begin
                    if (startRead) begin
                        state_reg <= STATE_READ;
                    end else if (startWrite) begin
                        state_reg <= STATE_WRITE;
                    end
                end
                STATE_READ: begin
                    if (bus_fault_input) begin
                        state_reg <= STATE_IDLE;
                    end else if (read_buffer_clock_enable
                            && (filled_reg + 1'b1 == wordsWanted)) begin
                        // Last word's enable moves to drain here, its buffer write still due
                        state_reg <= STATE_DRAIN;
                    end
                end
                STATE_DRAIN: begin
                    if (drained_reg == wordsWanted) begin
                        state_reg <= STATE_IDLE;
                    end
                end
                STATE_WRITE: begin
                    if (acknowledge || bus_fault_input) begin
                        state_reg <= STATE_IDLE;
                    end
                end
                default: state_reg <= STATE_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Strobes, qualifier, address and write data
    always_ff @(posedge clock) begin
        if (reset) begin
            readStrobe          <= 1'b0;
            writeStrobe         <= 1'b0;
            burst_or_near_write <= 1'b0;
            data_drive_enable   <= 1'b0;
            busAddress          <= '0;
            busWriteData        <= '0;
            burst_reg           <= 1'b0;
        end else if (startRead) begin
            readStrobe          <= 1'b1;
            burst_or_near_write <= requestBurst;
            burst_reg           <= requestBurst;
            busAddress          <= requestAddress;
        end else if (startWrite) begin
            writeStrobe         <= 1'b1;
            data_drive_enable   <= 1'b1;
            burst_or_near_write <= samePage(requestAddress, lastPage_reg,
                                            lastPageValid_reg);
            burst_reg           <= 1'b0;
            busAddress          <= requestAddress;
            busWriteData        <= requestData;
        end else if (bus_fault_input) begin
            // Any cycle type gives up its strobe one clock after a fault
            readStrobe          <= 1'b0;
            writeStrobe         <= 1'b0;
            data_drive_enable   <= 1'b0;
            burst_or_near_write <= 1'b0;
        end else if ((state_reg == STATE_WRITE) && acknowledge) begin
            writeStrobe         <= 1'b0;
            data_drive_enable   <= 1'b0;
            burst_or_near_write <= 1'b0;
        end else if ((state_reg == STATE_READ) && read_buffer_clock_enable
                     && (filled_reg + 1'b1 == wordsWanted)) begin
            readStrobe          <= 1'b0;
            burst_or_near_write <= 1'b0;
        end
    end

    // Page of the last write, for the near qualifier
    always_ff @(posedge clock) begin
        if (reset) begin
            lastPage_reg      <= '0;
            lastPageValid_reg <= 1'b0;
        end else if (startWrite) begin
            lastPage_reg      <= requestAddress[ADDR_WIDTH-1:PAGE_LOW_BIT];
            lastPageValid_reg <= 1'b1;
        end
    end

    // ==========================================================
    // Read buffer fill
    // Sample now, write the buffer one step later, like the half-cycle gap
    always_ff @(posedge clock) begin
        if (reset) begin
            enableSeen_reg  <= 1'b0;
            sampledData_reg <= '0;
            filled_reg      <= '0;
        end else begin
            enableSeen_reg  <= (state_reg == STATE_READ)
                               && read_buffer_clock_enable
                               && !bus_fault_input;
            sampledData_reg <= busReadData;
            if (startRead) begin
                filled_reg <= '0;
            end else if ((state_reg == STATE_READ)
                         && read_buffer_clock_enable) begin
                filled_reg <= filled_reg + 1'b1;
            end
        end
    end

    assign bufferPort.fillEnable = enableSeen_reg;
    assign bufferPort.fillData   = sampledData_reg;
    // Index follows the count sampled in the cycle before the write
    assign bufferPort.fillIndex  = WORD_INDEX_WIDTH'(filled_reg - 1'b1);
    assign bufferPort.drainIndex = drained_reg[WORD_INDEX_WIDTH-1:0];

    read_buffer #(
        .DEPTH (BURST_WORDS)
    ) buffer (
        .clock (clock),
        .port  (bufferPort.storage)
    );

    // ==========================================================
    // Drain start and one word per clock
    always_ff @(posedge clock) begin
        if (reset || startRead) begin
            drainGo_reg <= 1'b0;
        end else if ((state_reg == STATE_READ) && burst_reg
                     && acknowledge) begin
            drainGo_reg <= 1'b1;
        end
    end

    // Early acknowledge can outrun the memory, so an empty slot stalls
    always_ff @(posedge clock) begin
        if (reset) begin
            drained_reg   <= '0;
            readDataValid <= 1'b0;
            readData      <= '0;
        end else begin
            readDataValid <= 1'b0;
            if (startRead) begin
                drained_reg <= '0;
            end else if (((state_reg == STATE_DRAIN)
                          || ((state_reg == STATE_READ) && drainGo_reg))
                         && (drained_reg < wordsWanted)
                         && (drained_reg < filled_reg)
                         && !((drained_reg + 1'b1 == filled_reg)
                              && enableSeen_reg)) begin
                drained_reg   <= drained_reg + 1'b1;
                readDataValid <= 1'b1;
                readData      <= bufferPort.drainData;
            end
        end
    end

    // ==========================================================
    // Completion and bus error reporting
    always_ff @(posedge clock) begin
        if (reset) begin
            requestReady      <= 1'b0;
            readDone          <= 1'b0;
            writeDone         <= 1'b0;
            busErrorException <= 1'b0;
        end else begin
            requestReady      <= (state_reg == STATE_IDLE) && !requestValid;
            readDone          <= (state_reg == STATE_DRAIN)
                                 && (drained_reg == wordsWanted);
            writeDone         <= (state_reg == STATE_WRITE)
                                 && (acknowledge || bus_fault_input);
            // Faults on writes pass silently; only reads raise one
            busErrorException <= (state_reg == STATE_READ)
                                 && bus_fault_input;
        end
    end
endmodule : memory_wait_state_handshake
`default_nettype wire

// ==== memory_wait_state_handshake_monitor.sv ====
// Port checker for the processor bus engine
`timescale 1ns/1ps
`default_nettype none
module handshake_monitor
    import memory_wait_state_pkg::*;
(
    input wire logic                  clock,
    input wire logic                  reset,
    input wire logic                  requestBurst,
    input wire logic                  readStrobe,
    input wire logic                  writeStrobe,
    input wire logic                  burst_or_near_write,
    input wire logic                  read_buffer_clock_enable,
    input wire logic                  acknowledge,
    input wire logic                  bus_fault_input,
    input wire logic                  readDataValid,
    input wire logic                  readDone,
    input wire logic                  writeDone,
    input wire logic                  busErrorException,
    input wire logic [MODE_WIDTH-1:0] mode_vector_interrupt_inputs,
    input wire logic                  byte_order_select,
    input wire logic                  data_refill_block_select
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    // ==========================================================
    // Handshake and fault relations
    fault_drop_a : assert property (
        (readStrobe | writeStrobe) & bus_fault_input
        |=> !readStrobe && !writeStrobe)
        else $error("strobe held after bus fault");
    read_exception_a : assert property (
        readStrobe & bus_fault_input |=> busErrorException)
        else $error("read fault without exception");
    write_no_exception_a : assert property (
        writeStrobe & bus_fault_input |=> !busErrorException && writeDone)
        else $error("write fault raised exception");
    write_end_a : assert property (
        writeStrobe & acknowledge |=> !writeStrobe && writeDone)
        else $error("write not ended by acknowledge");
    read_qualifier_a : assert property (
        $rose(readStrobe) |-> burst_or_near_write == $past(requestBurst))
        else $error("read qualifier wrong");
    single_end_a : assert property (
        readStrobe & !burst_or_near_write & read_buffer_clock_enable
        |=> !readStrobe ##[0:3] readDataValid)
        else $error("single read not ended by its enable");
    burst_drain_a : assert property (
        readStrobe & burst_or_near_write & acknowledge
        |-> ##[1:8] readDataValid)
        else $error("burst drain did not start");
    done_after_word_a : assert property (
        readDone |-> $past(readDataValid))
        else $error("read done without last word");
    mode_capture_a : assert property (
        $fell(reset) |=> byte_order_select ==
        $past(mode_vector_interrupt_inputs[MODE_BYTE_ORDER_BIT])
        && data_refill_block_select ==
        $past(mode_vector_interrupt_inputs[MODE_REFILL_BIT]))
        else $error("mode vector not captured");
endmodule : handshake_monitor
bind memory_wait_state_handshake handshake_monitor monitor (.clock, .reset,
    .requestBurst, .readStrobe, .writeStrobe, .burst_or_near_write,
    .read_buffer_clock_enable, .acknowledge, .bus_fault_input, .readDataValid,
    .readDone, .writeDone, .busErrorException, .mode_vector_interrupt_inputs,
    .byte_order_select, .data_refill_block_select);
`default_nettype wire

// ==== memory_wait_state_handshake_tb.sv ====
// Self-checking bench for the bus handshake engine
`timescale 1ns/1ps
`default_nettype none
module memory_wait_state_handshake_tb;
    import memory_wait_state_pkg::*;
    logic                  clock = 1'b0, reset = 1'b1, requestValid = 1'b0;
    logic                  requestWrite = 1'b0, requestBurst = 1'b0;
    logic [ADDR_WIDTH-1:0] requestAddress = '0, busAddress;
    logic [DATA_WIDTH-1:0] requestData = '0, readData, busWriteData, busReadData;
    logic                  requestReady, readDataValid, readDone, writeDone;
    logic                  busErrorException, readStrobe, writeStrobe;
    logic                  burst_or_near_write, data_drive_enable, acknowledge;
    logic                  read_buffer_clock_enable, bus_fault_input;
    logic [MODE_WIDTH-1:0] modeVector = '0;
    logic                  byte_order_select, data_refill_block_select, hasWrite;
    logic [33:0]           expQ [$];
    logic [33:0]           seen;
    logic [21:0]           lastPage;
    logic [31:0]           r;
    int                    failures = 0, num_checks = 0, seed = 32'hc0d6;
    always #50 clock = ~clock;
    memory_wait_state_handshake dut (.clock, .reset, .requestValid,
        .requestWrite, .requestBurst, .requestAddress, .requestData,
        .requestReady, .readDataValid, .readData, .readDone, .writeDone,
        .busErrorException, .readStrobe, .writeStrobe, .burst_or_near_write,
        .data_drive_enable, .busAddress, .busWriteData, .busReadData,
        .read_buffer_clock_enable, .acknowledge, .bus_fault_input,
        .mode_vector_interrupt_inputs(modeVector), .byte_order_select,
        .data_refill_block_select);
    wait_state_model partner (.clock, .reset, .readStrobe, .writeStrobe,
        .burst_or_near_write, .busAddress, .read_buffer_clock_enable,
        .acknowledge, .bus_fault_input, .busReadData);
    // ==========================================================
    // Compare, close and scoreboard
    task automatic check(input string what, input logic [33:0] got,
                         input logic [33:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : close_out
    // Sampled mid-cycle so one-cycle pulses are settled
    always @(negedge clock) begin
        if (!reset && (readDataValid | readDone | writeDone | busErrorException)
            === 1'b1) begin
            seen = {busErrorException ? 2'd3 : writeDone ? 2'd2 : {1'b0, readDone},
                    readDataValid ? readData : 32'h0};
            check("event", seen, expQ.size() > 0 ? expQ.pop_front() : 34'bx);
        end
    end
    // ==========================================================
    // Drivers
    task automatic do_reset;
        @(posedge clock);
        modeVector <= 3'($random(seed));
        reset <= 1'b1;
        repeat (5) @(posedge clock);
        reset <= 1'b0;
        hasWrite = 1'b0;
        repeat (2) @(posedge clock);
        @(negedge clock);
        check("ready", {33'h0, requestReady}, 34'h1);
        check("order", {33'h0, byte_order_select},
              {33'h0, modeVector[MODE_BYTE_ORDER_BIT]});
        check("refill", {33'h0, data_refill_block_select},
              {33'h0, modeVector[MODE_REFILL_BIT]});
    endtask : do_reset
    task automatic do_op(input logic wr, input logic burst, input logic [31:0] addr);
        int n;
        logic near;
        logic [31:0] wdata;
        wdata = $random(seed);
        near = wr & hasWrite & (addr[31:10] === lastPage);
        if (addr[31] | wr) begin
            expQ.push_back({wr ? 2'd2 : 2'd3, 32'h0});
        end else begin
            for (n = 0; n < (burst ? 4 : 1); n++) expQ.push_back({2'd0, addr ^ 32'(n)});
            expQ.push_back({2'd1, 32'h0});
        end
        @(posedge clock);
        requestValid <= 1'b1;
        requestWrite <= wr;
        requestBurst <= burst & ~wr;
        requestAddress <= addr;
        requestData <= wdata;
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while ((readStrobe | writeStrobe) !== 1'b1 && n < 10);
        check("qualifier", {33'h0, burst_or_near_write},
              {33'h0, wr ? near : burst});
        if (wr) check("wdata", {2'd0, busWriteData}, {2'd0, wdata});
        check("address", {2'd0, busAddress}, {2'd0, addr});
        check("drive", {33'h0, data_drive_enable}, {33'h0, wr});
        @(posedge clock);
        requestValid <= 1'b0;
        if (wr) begin
            hasWrite = 1'b1;
            lastPage = addr[31:10];
        end
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while ((expQ.size() != 0 || requestReady !== 1'b1) && n < 60);
        if (n >= 60) check("completion", 34'h0, 34'h1);
    endtask : do_op
    // ==========================================================
    // Scenarios
    initial begin
        do_reset();
        do_op(1'b0, 1'b0, 32'h0000_1000);
        do_op(1'b0, 1'b1, 32'h0000_1010);
        $display("reads done");
        do_op(1'b1, 1'b0, 32'h0000_2000);
        do_op(1'b1, 1'b0, 32'h0000_23fc);
        do_op(1'b1, 1'b0, 32'h0000_2400);
        $display("writes done");
        repeat (16) begin
            r = $random(seed);
            do_op(r[0], r[1], {1'b0, r[30:4], 4'h0});
        end
        $display("random done");
        do_reset();
        do_op(1'b1, 1'b0, 32'h8000_0000);
        do_op(1'b0, 1'b1, 32'h8000_0010);
        do_op(1'b0, 1'b0, 32'h0000_0040);
        $display("faults done");
        close_out();
    end
    initial begin
        #(100 * 5000);
        failures++;
        close_out();
    end
endmodule : memory_wait_state_handshake_tb
`default_nettype wire

// ==== memory_wait_state_pkg.sv ====
// Shared constants and types for the memory bus handshake engine
package memory_wait_state_pkg;
    // ==========================================================
    // Bus geometry
    localparam int DATA_WIDTH  = 32;
    localparam int ADDR_WIDTH  = 32;
    localparam int BURST_WORDS = 4;
    localparam int WORD_INDEX_WIDTH = 2;
    // Near-write page: 256 words, so word address bits 9:2 are in-page
    localparam int PAGE_LOW_BIT = 10;
    // ==========================================================
    // Mode vector layout on the interrupt inputs
    localparam int MODE_WIDTH          = 3;
    localparam int MODE_BYTE_ORDER_BIT = 0;
    localparam int MODE_REFILL_BIT     = 2;
    localparam logic BYTE_ORDER_RESET  = 1'b0;
    localparam logic REFILL_RESET      = 1'b0;
    // ==========================================================
    // Bus engine states, one-hot
    typedef enum logic [3:0] {
        STATE_IDLE  = 4'h1,
        STATE_READ  = 4'h2,
        STATE_DRAIN = 4'h4,
        STATE_WRITE = 4'h8
    } bus_state_type;
endpackage : memory_wait_state_pkg

// ==== read_buffer.sv ====
// Four-word read buffer, filled by the link, drained by the engine
`timescale 1ns/1ps
`default_nettype none
module read_buffer
    import memory_wait_state_pkg::*;
#(
    parameter int DEPTH = BURST_WORDS
) (
    input  wire logic     clock,
    read_buffer_if.storage port
);
    logic [DATA_WIDTH-1:0] words_reg [DEPTH];

    // ==========================================================
    // Storage
    always_ff @(posedge clock) begin
        if (port.fillEnable) begin
            words_reg[port.fillIndex] <= port.fillData;
        end
    end

    assign port.drainData = words_reg[port.drainIndex];
endmodule : read_buffer
`default_nettype wire

// ==== read_buffer_if.sv ====
// Carrier between the bus engine and its read buffer
`timescale 1ns/1ps
`default_nettype none
interface read_buffer_if;
    import memory_wait_state_pkg::*;
    logic                        fillEnable;
    logic [WORD_INDEX_WIDTH-1:0] fillIndex;
    logic [DATA_WIDTH-1:0]       fillData;
    logic [WORD_INDEX_WIDTH-1:0] drainIndex;
    logic [DATA_WIDTH-1:0]       drainData;
    modport engine (output fillEnable, output fillIndex, output fillData,
                    output drainIndex, input drainData);
    modport storage (input fillEnable, input fillIndex, input fillData,
                     input drainIndex, output drainData);
endinterface : read_buffer_if
`default_nettype wire

// ==== wait_state_model.sv ====
// Far-side wait-state controller answering the bus engine
`timescale 1ns/1ps
`default_nettype none
module wait_state_model
    import memory_wait_state_pkg::*;
(
    input  wire logic                  clock,
    input  wire logic                  reset,
    input  wire logic                  readStrobe,
    input  wire logic                  writeStrobe,
    input  wire logic                  burst_or_near_write,
    input  wire logic [ADDR_WIDTH-1:0] busAddress,
    output logic                       read_buffer_clock_enable,
    output logic                       acknowledge,
    output logic                       bus_fault_input,
    output logic [DATA_WIDTH-1:0]      busReadData
);
    // ==========================================================
    // Counter and decodes
    logic [3:0]            count_reg;
    logic [DATA_WIDTH-1:0] wordValue;
    logic                  selRead, selWrite, cycleDone, memDrive;
    // Upper half of the map is empty, so it only times out
    assign selRead = readStrobe & ~busAddress[31];
    assign selWrite = writeStrobe & ~busAddress[31];
    assign read_buffer_clock_enable = ~reset & selRead & (count_reg == 4'h2 |
        (burst_or_near_write & count_reg >= 4'h3 & count_reg <= 4'h5));
    assign cycleDone = (selRead & count_reg == (burst_or_near_write ? 4'h5 : 4'h2))
        | (selWrite & count_reg == (burst_or_near_write ? 4'h2 : 4'h3));
    assign bus_fault_input = (readStrobe | writeStrobe) & count_reg == 4'hf;
    // Early ack on bursts lets the drain overlap the late words
    assign acknowledge = (selWrite & cycleDone)
        | (selRead & burst_or_near_write & count_reg == 4'h2);
    assign wordValue = busAddress ^ {30'h0, count_reg[1:0] - 2'h2};
    // Output enable held from data ready until the strobe drops
    assign memDrive = selRead & (count_reg >= 4'h2);
    // Released bus shows the inverse so stale data never matches
    assign busReadData = memDrive ? wordValue : ~wordValue;
    always_ff @(posedge clock) begin
        if (reset | cycleDone | bus_fault_input | ~(readStrobe | writeStrobe))
            count_reg <= 4'h0;
        else
            count_reg <= count_reg + 4'h1;
    end
endmodule : wait_state_model
`default_nettype wire
